// ==== pin_cfg_consts.vh ====
// Purpose: shared constants of the pin configuration and gate output controller
// Assumes: 50 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes: times in their own unit, cycle counts derived from them
`ifndef PIN_CFG_CONSTS_VH
`define PIN_CFG_CONSTS_VH

// ==========================================================
// clock and times
`define CLK_PERIOD_NS 20
`define LOAD_TIME_US 5000
`define LOAD_CYCLES ((`LOAD_TIME_US * 1000) / `CLK_PERIOD_NS)
`define ENA_DELAY_NS 1000
`define ENA_DELAY_CYC ((`ENA_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFF_DELAY_NS 1000
`define OFF_DELAY_CYC ((`OFF_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FALL_TIME_NS 20000
`define FALL_TIME_CYC ((`FALL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================
// register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_VOUT 8'h08
`define REG_VCEIL 8'h0C
`define REG_SLV_ADDR 8'h10
`define REG_PIN_KIND 8'h14
`define REG_ENA_DLY 8'h18
`define REG_OFF_DLY 8'h1C
`define REG_FALL_TIME 8'h20

// ==========================================================
// control and status bits
`define CTRL_BUS_EN 0
`define CTRL_RESTORE 1
`define CTRL_STORE 2
`define ST_READY 0
`define ST_HW_EN 1
`define ST_DRV_EN 2
`define ST_PULSE_OE 3
`define ST_NVM_LOADED 4

// ==========================================================
// connection kinds of a multi-mode pin
`define KIND_LOW 2'h0
`define KIND_OPEN 2'h1
`define KIND_HIGH 2'h2
`define KIND_RES 2'h3
`define RES_SEL_MAX 5'h1E

// ==========================================================
// reset values and stored image
`define VOUT_RST 10'h078
`define SLV_ADDR_BASE 7'h20
`define NVM_SIG 16'hC5A3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== multimode_pin_decoder.v ====
// Purpose: classify one multi-mode configuration pin
// Assumes: analog front end gives a kind code and a resistor index
// Notes: combinational; the caller latches the result
module multimode_pin_decoder (
	input wire [1:0] pin_kind,
	input wire [4:0] pin_res_idx,
	output wire is_res,
	output wire [1:0] level,
	output wire [4:0] res_sel
);
`include "pin_cfg_consts.vh"

	// ======================================================
	// classification
	// four connection kinds
	assign is_res = (pin_kind == `KIND_RES);
	assign level = is_res ? `KIND_LOW : pin_kind;
	assign res_sel = !is_res ? 5'h00 :
		((pin_res_idx > `RES_SEL_MAX) ? `RES_SEL_MAX : pin_res_idx);

endmodule // multimode_pin_decoder

// ==== delay_timer.v ====
// Purpose: down counter giving one done pulse after a loaded count
// Assumes: count of zero behaves as one
// Notes: abort cancels a running count
module delay_timer #(
	parameter W = 16
) (
	input wire aclk,
	input wire aresetn,
	input wire start,
	input wire abort,
	input wire [W-1:0] count,
	output wire done,
	output wire busy
);

	reg [W-1:0] cnt_q;
	reg busy_q;

	// ======================================================
	// counter
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= {W{1'b0}};
			busy_q <= 1'b0;
		end else if (abort) begin
			busy_q <= 1'b0;
		end else if (start) begin
			busy_q <= 1'b1;
			cnt_q <= (count == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : count;
		end else if (busy_q) begin
			if (cnt_q == {{(W-1){1'b0}}, 1'b1})
				busy_q <= 1'b0;
			else
				cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign done = busy_q && !abort && (cnt_q == {{(W-1){1'b0}}, 1'b1});
	assign busy = busy_q;

endmodule // delay_timer

// ==== pin_config_and_gate_output_ctrl.v ====
// Purpose: pin configuration loader and gate pulse output control
// Assumes: pin kinds come digitised; pwm levels come from the loop
// Notes: store image survives aresetn but not power loss of the sim
`include "pin_cfg_consts.vh"

// What this block does
// - With neither hardware nor bus enable, both pulse outputs float.
// - The floating of the pulse outputs cannot be turned off by any setting.
// - An enable raises driver_enable_out after enable_assert_delay.
// - After disable, driver_enable_out falls after the fall period plus disable_release_delay.
// - Each multi-mode pin is classed low, open, high or resistor.
// - Pins are sampled after power-up and on each restore command.
// - A strap pin gives three levels and a pair gives nine settings.
// - A resistor pin gives up to 31 selections.
// - The slave address comes only from the two address pins.
// - The voltage ceiling is 10% above the pin-selected output voltage.
// - Pin-set parameters stay readable; of them only the output voltage can be overwritten by the bus.
// - All other parameters are writable over the bus.
// - The current configuration can be stored into nonvolatile_store.
// - Start-up loads stored values first, then the pin settings.
module pin_config_and_gate_output_ctrl #(
	parameter LOAD_CYCLES = `LOAD_CYCLES,
	parameter DLY_W = 16
) (
	input wire aclk,
	input wire aresetn,
	input wire awvalid,
	output wire awready,
	input wire [7:0] awaddr,
	input wire [2:0] awprot,
	input wire wvalid,
	output wire wready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	output wire bvalid,
	input wire bready,
	output wire [1:0] bresp,
	input wire arvalid,
	output wire arready,
	input wire [7:0] araddr,
	input wire [2:0] arprot,
	output wire rvalid,
	input wire rready,
	output wire [31:0] rdata,
	output wire [1:0] rresp,
	input wire hw_enable,
	input wire [1:0] addr_sel_pin0_kind,
	input wire [4:0] addr_sel_pin0_res,
	input wire [1:0] addr_sel_pin1_kind,
	input wire [4:0] addr_sel_pin1_res,
	input wire [1:0] voltage_sel_fine_pin_kind,
	input wire [4:0] voltage_sel_fine_pin_res,
	input wire [1:0] voltage_sel_coarse_pin_kind,
	input wire [4:0] voltage_sel_coarse_pin_res,
	input wire pwm_high_in,
	input wire pwm_low_in,
	output wire high_side_pulse_out,
	output wire high_side_pulse_oe,
	output wire low_side_pulse_out,
	output wire low_side_pulse_oe,
	output wire driver_enable_out,
	output wire config_ready,
	output wire [6:0] slave_addr,
	output wire [10:0] output_voltage_ceiling
);

	localparam SEQ_LOAD = 2'h0;
	localparam SEQ_PINS = 2'h1;
	localparam SEQ_READY = 2'h2;
	localparam DRV_OFF = 3'h0;
	localparam DRV_WAIT = 3'h1;
	localparam DRV_ON = 3'h2;
	localparam DRV_FALL = 3'h3;
	localparam DRV_REL = 3'h4;
	localparam [23:0] LOAD_END = LOAD_CYCLES;
	localparam [DLY_W-1:0] ENA_RST = `ENA_DELAY_CYC;
	localparam [DLY_W-1:0] OFF_RST = `OFF_DELAY_CYC;
	localparam [DLY_W-1:0] FALL_RST = `FALL_TIME_CYC;

	// ======================================================
	// declarations
	reg [1:0] seq_q;
	reg nvm_loaded_q;
	reg bus_en_q;
	reg [9:0] vout_q;
	reg [10:0] vceil_q;
	reg [6:0] slv_addr_q;
	reg [7:0] pin_kind_q;
	reg [DLY_W-1:0] ena_dly_q;
	reg [DLY_W-1:0] off_dly_q;
	reg [DLY_W-1:0] fall_q;
	reg [15:0] nvm_mem [0:4];
	reg aw_full_q;
	reg [7:0] aw_addr_q;
	reg w_full_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;
	reg [31:0] rd_d;
	reg rd_ok;
	reg [2:0] drv_q;
	reg [2:0] drv_d;
	reg drv_en_q;
	reg pulse_oe_q;
	reg pwm_h_q;
	reg pwm_l_q;
	wire do_write;
	wire [31:0] wmask;
	wire [31:0] wval;
	wire restore_cmd;
	wire store_cmd;
	wire sample;
	wire load_done;
	wire en_req;
	wire ena_done;
	wire fall_done;
	wire off_done;
	wire a0_res;
	wire a1_res;
	wire f_res;
	wire c_res;
	wire [1:0] a0_lvl;
	wire [1:0] a1_lvl;
	wire [1:0] f_lvl;
	wire [1:0] c_lvl;
	wire [4:0] a0_sel;
	wire [4:0] a1_sel;
	wire [4:0] f_sel;
	wire [4:0] c_sel;
	wire [3:0] v_pair;
	wire [9:0] v_pins;
	wire [13:0] v_times11;
	wire [13:0] v_ceil;

	// ======================================================
	// pin decoders
	multimode_pin_decoder u_a0 (.pin_kind(addr_sel_pin0_kind), .pin_res_idx(addr_sel_pin0_res),
		.is_res(a0_res), .level(a0_lvl), .res_sel(a0_sel));
	multimode_pin_decoder u_a1 (.pin_kind(addr_sel_pin1_kind), .pin_res_idx(addr_sel_pin1_res),
		.is_res(a1_res), .level(a1_lvl), .res_sel(a1_sel));
	multimode_pin_decoder u_vf (.pin_kind(voltage_sel_fine_pin_kind),
		.pin_res_idx(voltage_sel_fine_pin_res), .is_res(f_res), .level(f_lvl), .res_sel(f_sel));
	multimode_pin_decoder u_vc (.pin_kind(voltage_sel_coarse_pin_kind),
		.pin_res_idx(voltage_sel_coarse_pin_res), .is_res(c_res), .level(c_lvl), .res_sel(c_sel));

	// ======================================================
	// voltage from pins, 10 mV units
	// pair picks one of nine
	assign v_pair = {2'h0, c_lvl} * 4'h3 + {2'h0, f_lvl};
	function [9:0] strap_vout;
		input [3:0] idx;
		begin
			case (idx)
				4'h0: strap_vout = 10'h03C;
				4'h1: strap_vout = 10'h050;
				4'h2: strap_vout = 10'h064;
				4'h3: strap_vout = 10'h078;
				4'h4: strap_vout = 10'h096;
				4'h5: strap_vout = 10'h0B4;
				4'h6: strap_vout = 10'h0FA;
				4'h7: strap_vout = 10'h14A;
				4'h8: strap_vout = 10'h168;
				default: strap_vout = 10'h03C;
			endcase
		end
	endfunction
	assign v_pins = (f_res || c_res) ?
		({5'h00, c_sel} * 10'h019 + {5'h00, f_sel}) : strap_vout(v_pair);
	assign v_times11 = {4'h0, v_pins} * 14'h000B;
	assign v_ceil = v_times11 / 14'h000A;

	// ======================================================
	// load sequence
	delay_timer #(.W(24)) u_load (.aclk(aclk), .aresetn(aresetn),
		.start(1'b0), .abort(1'b0), .count(24'h000000), .done(), .busy());
	reg [23:0] load_cnt_q;
	assign load_done = (seq_q == SEQ_LOAD) && (load_cnt_q == LOAD_END);
	// sample after load and on restore
	assign sample = (seq_q == SEQ_PINS);
	always @(posedge aclk) begin
		if (!aresetn) begin
			seq_q <= SEQ_LOAD;
			load_cnt_q <= 24'h000000;
		end else begin
			case (seq_q)
				SEQ_LOAD: begin
					load_cnt_q <= load_cnt_q + 24'h000001;
					if (load_done)
						seq_q <= SEQ_PINS;
				end
				SEQ_PINS: seq_q <= SEQ_READY;
				SEQ_READY: begin
					if (restore_cmd)
						seq_q <= SEQ_PINS;
				end
				default: seq_q <= SEQ_LOAD;
			endcase
		end
	end

	// ======================================================
	// axi4-lite write
	assign awready = !aw_full_q && !bvalid_q;
	assign wready = !w_full_q && !bvalid_q;
	assign do_write = aw_full_q && w_full_q && !bvalid_q;
	assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign wval = w_data_q & wmask;
	assign restore_cmd = do_write && (aw_addr_q == `REG_CTRL) && wval[`CTRL_RESTORE];
	assign store_cmd = do_write && (aw_addr_q == `REG_CTRL) && wval[`CTRL_STORE];
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_full_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_full_q <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (do_write) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (aw_addr_q > `REG_FALL_TIME || aw_addr_q[1:0] != 2'h0) ?
					`RESP_SLVERR : `RESP_OKAY;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	// ======================================================
	// configuration registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			nvm_loaded_q <= 1'b0;
			bus_en_q <= 1'b0;
			vout_q <= `VOUT_RST;
			vceil_q <= 11'h000;
			slv_addr_q <= `SLV_ADDR_BASE;
			pin_kind_q <= 8'h00;
			ena_dly_q <= ENA_RST;
			off_dly_q <= OFF_RST;
			fall_q <= FALL_RST;
		end else begin
			if (load_done && nvm_mem[0] == `NVM_SIG) begin
				nvm_loaded_q <= 1'b1;
				vout_q <= nvm_mem[1][9:0];
				ena_dly_q <= nvm_mem[2][DLY_W-1:0];
				off_dly_q <= nvm_mem[3][DLY_W-1:0];
				fall_q <= nvm_mem[4][DLY_W-1:0];
			end
			if (sample) begin
				vout_q <= v_pins;
				vceil_q <= v_ceil[10:0];
				slv_addr_q <= `SLV_ADDR_BASE + (a0_res ? {2'h0, a0_sel} :
					{3'h0, {2'h0, a1_lvl} * 4'h3 + {2'h0, a0_lvl}});
				pin_kind_q <= {voltage_sel_coarse_pin_kind, voltage_sel_fine_pin_kind,
					addr_sel_pin1_kind, addr_sel_pin0_kind};
			end
			if (do_write) begin
				case (aw_addr_q)
					`REG_CTRL: bus_en_q <= wstrb_bit0(w_strb_q) ? wval[`CTRL_BUS_EN] : bus_en_q;
					`REG_VOUT: vout_q <= (vout_q & ~wmask[9:0]) | wval[9:0];
					`REG_ENA_DLY: ena_dly_q <= (ena_dly_q & ~wmask[DLY_W-1:0]) | wval[DLY_W-1:0];
					`REG_OFF_DLY: off_dly_q <= (off_dly_q & ~wmask[DLY_W-1:0]) | wval[DLY_W-1:0];
					`REG_FALL_TIME: fall_q <= (fall_q & ~wmask[DLY_W-1:0]) | wval[DLY_W-1:0];
					default: bus_en_q <= bus_en_q;
				endcase
			end
		end
	end
	function wstrb_bit0;
		input [3:0] s;
		begin
			wstrb_bit0 = s[0];
		end
	endfunction

	// ======================================================
	// nonvolatile store image, not cleared by reset
	// store current configuration
	always @(posedge aclk) begin
		if (store_cmd) begin
			nvm_mem[0] <= `NVM_SIG;
			nvm_mem[1] <= {6'h00, vout_q};
			nvm_mem[2] <= {{(16-DLY_W){1'b0}}, ena_dly_q};
			nvm_mem[3] <= {{(16-DLY_W){1'b0}}, off_dly_q};
			nvm_mem[4] <= {{(16-DLY_W){1'b0}}, fall_q};
		end
	end

	// ======================================================
	// axi4-lite read
	assign arready = !rvalid_q;
	always @* begin
		rd_d = 32'h00000000;
		rd_ok = 1'b1;
		case (araddr)
			`REG_CTRL: rd_d[`CTRL_BUS_EN] = bus_en_q;
			`REG_STATUS: rd_d[4:0] = {nvm_loaded_q, pulse_oe_q, drv_en_q, hw_enable,
				seq_q == SEQ_READY};
			`REG_VOUT: rd_d[9:0] = vout_q;
			`REG_VCEIL: rd_d[10:0] = vceil_q;
			`REG_SLV_ADDR: rd_d[6:0] = slv_addr_q;
			`REG_PIN_KIND: rd_d[7:0] = pin_kind_q;
			`REG_ENA_DLY: rd_d[DLY_W-1:0] = ena_dly_q;
			`REG_OFF_DLY: rd_d[DLY_W-1:0] = off_dly_q;
			`REG_FALL_TIME: rd_d[DLY_W-1:0] = fall_q;
			default: rd_ok = 1'b0;
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_d;
			rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// ======================================================
	// driver enable sequencing
	assign en_req = (seq_q == SEQ_READY) && (hw_enable || bus_en_q);
	delay_timer #(.W(DLY_W)) u_ena (.aclk(aclk), .aresetn(aresetn),
		.start(drv_q == DRV_OFF && en_req), .abort(drv_q == DRV_WAIT && !en_req),
		.count(ena_dly_q), .done(ena_done), .busy());
	delay_timer #(.W(DLY_W)) u_fall (.aclk(aclk), .aresetn(aresetn),
		.start(drv_q == DRV_ON && !en_req), .abort(drv_q == DRV_FALL && en_req),
		.count(fall_q), .done(fall_done), .busy());
	delay_timer #(.W(DLY_W)) u_off (.aclk(aclk), .aresetn(aresetn),
		.start(fall_done), .abort(drv_q == DRV_REL && en_req),
		.count(off_dly_q), .done(off_done), .busy());
	always @* begin
		drv_d = drv_q;
		case (drv_q)
			DRV_OFF: if (en_req) drv_d = DRV_WAIT;
			DRV_WAIT: begin
				if (!en_req)
					drv_d = DRV_OFF;
				else if (ena_done)
					drv_d = DRV_ON;
			end
			DRV_ON: if (!en_req) drv_d = DRV_FALL;
			DRV_FALL: begin
				if (en_req)
					drv_d = DRV_ON;
				else if (fall_done)
					drv_d = DRV_REL;
			end
			DRV_REL: begin
				if (en_req)
					drv_d = DRV_ON;
				else if (off_done)
					drv_d = DRV_OFF;
			end
			default: drv_d = DRV_OFF;
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			drv_q <= DRV_OFF;
			drv_en_q <= 1'b0;
			pulse_oe_q <= 1'b0;
			pwm_h_q <= 1'b0;
			pwm_l_q <= 1'b0;
		end else begin
			drv_q <= drv_d;
			drv_en_q <= (drv_d == DRV_ON) || (drv_d == DRV_FALL) || (drv_d == DRV_REL);
			pulse_oe_q <= (drv_d == DRV_ON);
			pwm_h_q <= pwm_high_in;
			pwm_l_q <= pwm_low_in;
		end
	end

	// ======================================================
	// outputs
	// float unless enabled, no override
	assign high_side_pulse_oe = pulse_oe_q && en_req;
	assign low_side_pulse_oe = pulse_oe_q && en_req;
	assign high_side_pulse_out = pwm_h_q;
	assign low_side_pulse_out = pwm_l_q;
	assign driver_enable_out = drv_en_q;
	assign config_ready = (seq_q == SEQ_READY);
	assign slave_addr = slv_addr_q;
	assign output_voltage_ceiling = vceil_q;

endmodule // pin_config_and_gate_output_ctrl

// ==== pin_config_and_gate_output_ctrl_sva.sv ====
// Purpose: concurrent checks on the ports of the pin configuration and gate output block
// Assumes: one clock domain, synchronous active-low reset
// Notes: delay bounds suit the short counts that the bench programs
module pin_config_and_gate_output_ctrl_sva (
	input wire aclk,
	input wire aresetn,
	input wire hw_enable,
	input wire [1:0] addr_sel_pin0_kind,
	input wire [4:0] addr_sel_pin0_res,
	input wire [1:0] addr_sel_pin1_kind,
	input wire [1:0] voltage_sel_fine_pin_kind,
	input wire [4:0] voltage_sel_fine_pin_res,
	input wire [1:0] voltage_sel_coarse_pin_kind,
	input wire [4:0] voltage_sel_coarse_pin_res,
	input wire high_side_pulse_oe,
	input wire low_side_pulse_oe,
	input wire driver_enable_out,
	input wire config_ready,
	input wire [6:0] slave_addr,
	input wire [10:0] output_voltage_ceiling
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int VT [9] = '{60, 80, 100, 120, 150, 180, 250, 330, 360};
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// expected pin decode
	function automatic int idx_of(input logic [1:0] k, input logic [4:0] r);
		return (k != 2'h3) ? 0 : ((r > 5'h1E) ? 30 : int'(r));
	endfunction
	function automatic int ceil_of(input logic [1:0] c, input logic [4:0] cr,
		input logic [1:0] f, input logic [4:0] fr);
		int v;
		v = (c == 2'h3 || f == 2'h3) ? idx_of(f, fr) + 25 * idx_of(c, cr) : VT[c * 3 + f];
		return v * 11 / 10;
	endfunction
	function automatic logic [6:0] addr_of(input logic [1:0] k0, input logic [4:0] r0,
		input logic [1:0] k1);
		return 7'(32'h20 + ((k0 == 2'h3) ? idx_of(k0, r0) : k1 * 3 + k0));
	endfunction
	// ==========================================================
	// properties
	sequence s_rise_late;
		!driver_enable_out [*2] ##[1:1000] driver_enable_out;
	endsequence
	sequence s_hold_then_drop;
		driver_enable_out [*4] ##[1:1000] !driver_enable_out;
	endsequence
	property p_float_unready;
		!config_ready |-> !high_side_pulse_oe && !low_side_pulse_oe;
	endproperty
	property p_oe_pair;
		(high_side_pulse_oe == low_side_pulse_oe) && (!high_side_pulse_oe || driver_enable_out);
	endproperty
	property p_oe_needs_drv;
		high_side_pulse_oe |=> driver_enable_out;
	endproperty
	property p_rise_delay;
		$rose(hw_enable) && config_ready && !driver_enable_out |-> s_rise_late;
	endproperty
	property p_fall_delay;
		$fell(hw_enable) && driver_enable_out |-> s_hold_then_drop;
	endproperty
	property p_restore_blip;
		$fell(config_ready) |=> config_ready;
	endproperty
	property p_addr_from_pins;
		$rose(config_ready) && addr_sel_pin1_kind != 2'h3 |->
			slave_addr == addr_of(addr_sel_pin0_kind, addr_sel_pin0_res, addr_sel_pin1_kind);
	endproperty
	property p_ceil_from_pins;
		$rose(config_ready) |-> output_voltage_ceiling == 11'(ceil_of(voltage_sel_coarse_pin_kind,
			voltage_sel_coarse_pin_res, voltage_sel_fine_pin_kind, voltage_sel_fine_pin_res));
	endproperty
	property p_addr_hold;
		config_ready && $past(config_ready) |-> $stable(slave_addr);
	endproperty
	property p_ceil_hold;
		config_ready && $past(config_ready) |-> $stable(output_voltage_ceiling);
	endproperty
	a_float_unready: assert property (p_float_unready) else $error("pulse output driven early");
	a_oe_pair: assert property (p_oe_pair) else $error("pulse enables disagree");
	a_oe_needs_drv: assert property (p_oe_needs_drv) else $error("driver enable low");
	a_rise_delay: assert property (p_rise_delay) else $error("driver enable timing");
	a_fall_delay: assert property (p_fall_delay) else $error("driver release timing");
	a_restore_blip: assert property (p_restore_blip) else $error("ready low too long");
	a_addr_from_pins: assert property (p_addr_from_pins) else $error("bad address");
	a_ceil_from_pins: assert property (p_ceil_from_pins) else $error("bad ceiling");
	a_addr_hold: assert property (p_addr_hold) else $error("address moved");
	a_ceil_hold: assert property (p_ceil_hold) else $error("ceiling moved");
endmodule // pin_config_and_gate_output_ctrl_sva

bind pin_config_and_gate_output_ctrl pin_config_and_gate_output_ctrl_sva
	u_pin_config_and_gate_output_ctrl_sva (
	.aclk(aclk), .aresetn(aresetn), .hw_enable(hw_enable),
	.addr_sel_pin0_kind(addr_sel_pin0_kind), .addr_sel_pin0_res(addr_sel_pin0_res),
	.addr_sel_pin1_kind(addr_sel_pin1_kind),
	.voltage_sel_fine_pin_kind(voltage_sel_fine_pin_kind),
	.voltage_sel_fine_pin_res(voltage_sel_fine_pin_res),
	.voltage_sel_coarse_pin_kind(voltage_sel_coarse_pin_kind),
	.voltage_sel_coarse_pin_res(voltage_sel_coarse_pin_res),
	.high_side_pulse_oe(high_side_pulse_oe), .low_side_pulse_oe(low_side_pulse_oe),
	.driver_enable_out(driver_enable_out), .config_ready(config_ready),
	.slave_addr(slave_addr), .output_voltage_ceiling(output_voltage_ceiling)
);

// ==== gate_driver_model.sv ====
// Purpose: behavioural external gate driver at the pulse outputs
// Assumes: no pull resistors on its pulse inputs
// Notes: a released input shows a level that flips every cycle
module gate_driver_model (
	input wire aclk,
	input wire hs_in,
	input wire hs_oe,
	input wire ls_in,
	input wire ls_oe,
	input wire drv_en,
	output logic hs_gate,
	output logic ls_gate,
	output logic released
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hs_last = 1'h0;
	logic ls_last = 1'h0;
	wire hs_line = hs_oe ? hs_in : ~hs_last;
	wire ls_line = ls_oe ? ls_in : ~ls_last;
	always @(posedge aclk) begin
		hs_last <= hs_line;
		ls_last <= ls_line;
	end
	// mid-level inputs keep both switches off
	assign hs_gate = drv_en && hs_oe && hs_line;
	assign ls_gate = drv_en && ls_oe && ls_line;
	assign released = !hs_oe && !ls_oe;
endmodule // gate_driver_model

// ==== pin_config_and_gate_output_ctrl_test.sv ====
// Purpose: self-checking bench of the pin configuration and gate output block
// Assumes: short load count, bus-programmed short delays
// Notes: the store image survives the mid-run reset
`include "pin_cfg_consts.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module pin_config_and_gate_output_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0, aresetn = 1'h0, hw_enable = 1'h0, pwm_high_in = 1'h1, pwm_low_in = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rd;
	logic [1:0] k0 = 2'h1, k1 = 2'h2, kf = 2'h2, kc = 2'h1, rsp;
	logic [4:0] r0 = 5'h00, rf = 5'h00, rc = 5'h00;
	wire awready, wready, bvalid, arready, rvalid, hs_out, hs_oe, ls_out, ls_oe;
	wire driver_enable_out, config_ready, hs_gate, ls_gate, released;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [6:0] slave_addr;
	wire [10:0] output_voltage_ceiling;
	int err_count = 0, comparisons = 0, n;
	pin_config_and_gate_output_ctrl #(.LOAD_CYCLES(20)) u_pin_config_and_gate_output_ctrl (
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .hw_enable(hw_enable), .addr_sel_pin0_kind(k0),
		.addr_sel_pin0_res(r0), .addr_sel_pin1_kind(k1), .addr_sel_pin1_res(5'h00),
		.voltage_sel_fine_pin_kind(kf), .voltage_sel_fine_pin_res(rf),
		.voltage_sel_coarse_pin_kind(kc), .voltage_sel_coarse_pin_res(rc),
		.pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in), .high_side_pulse_out(hs_out),
		.high_side_pulse_oe(hs_oe), .low_side_pulse_out(ls_out), .low_side_pulse_oe(ls_oe),
		.driver_enable_out(driver_enable_out), .config_ready(config_ready),
		.slave_addr(slave_addr), .output_voltage_ceiling(output_voltage_ceiling));
	gate_driver_model u_gate_driver_model (.aclk(aclk), .hs_in(hs_out), .hs_oe(hs_oe),
		.ls_in(ls_out), .ls_oe(ls_oe), .drv_en(driver_enable_out), .hs_gate(hs_gate),
		.ls_gate(ls_gate), .released(released));
	always #10 aclk = ~aclk;
	// ==========================================================
	// bus and wait tasks
	task automatic cyc(input int c);
		repeat (c) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ap = 1'h1, wp = 1'h1, bp = 1'h1;
		int t = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (bp && t < 200) begin
			@(posedge aclk);
			t++;
			if (ap && awready) begin
				ap = 1'h0;
				awvalid <= 1'h0;
			end
			if (wp && wready) begin
				wp = 1'h0;
				wvalid <= 1'h0;
			end
			if (bvalid) begin
				bp = 1'h0;
				rsp = bresp;
				bready <= 1'h0;
			end
		end
		if (bp) err_count++;
		@(posedge aclk);
	endtask
	task automatic rdr(input logic [7:0] a);
		logic ap = 1'h1, rp = 1'h1;
		int t = 0;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (rp && t < 200) begin
			@(posedge aclk);
			t++;
			if (ap && arready) begin
				ap = 1'h0;
				arvalid <= 1'h0;
			end
			if (rvalid) begin
				rp = 1'h0;
				rd = rdata;
				rsp = rresp;
				rready <= 1'h0;
			end
		end
		if (rp) err_count++;
		@(posedge aclk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rdr(a);
		`CHK(rd, e)
	endtask
	task automatic wait_rdy;
		n = 0;
		while (config_ready !== 1'h1 && n < 200) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 200) err_count++;
	endtask
	task automatic wait_drv(input logic want);
		n = 0;
		while (driver_enable_out !== want && n < 300) begin
			@(posedge aclk);
			n++;
		end
	endtask
	// ==========================================================
	// scenarios
	task automatic t_load;
		`CHK(hs_oe, 1'h0)
		`CHK(slave_addr, 7'h20)
		wait_rdy();
		`CHK(slave_addr, 7'h27)
		`CHK(output_voltage_ceiling, 11'h0C6)
		`CHK(released, 1'h1)
		rchk(`REG_VOUT, 32'hB4);
		rchk(`REG_ENA_DLY, 32'h32);
		rchk(`REG_FALL_TIME, 32'h3E8);
		rchk(`REG_PIN_KIND, 32'h69);
	endtask
	task automatic t_restore;
		k0 <= 2'h3;
		r0 <= 5'h03;
		kf <= 2'h3;
		rf <= 5'h08;
		kc <= 2'h3;
		rc <= 5'h05;
		cyc(4);
		`CHK(slave_addr, 7'h27)
		wr(`REG_CTRL, 32'h2);
		wait_rdy();
		`CHK(slave_addr, 7'h23)
		`CHK(output_voltage_ceiling, 11'h092)
		rchk(`REG_VOUT, 32'h85);
		rchk(`REG_PIN_KIND, 32'hFB);
	endtask
	task automatic t_bus;
		wr(`REG_VOUT, 32'hAA);
		rchk(`REG_VOUT, 32'hAA);
		wr(`REG_SLV_ADDR, 32'h55);
		rchk(`REG_SLV_ADDR, 32'h23);
		`CHK(output_voltage_ceiling, 11'h092)
		wr(8'h40, 32'h1);
		`CHK(rsp, `RESP_SLVERR)
		rchk(8'h40, 32'h0);
		`CHK(rsp, `RESP_SLVERR)
	endtask
	task automatic t_hw;
		wr(`REG_ENA_DLY, 32'h5);
		wr(`REG_OFF_DLY, 32'h4);
		wr(`REG_FALL_TIME, 32'hA);
		rchk(`REG_OFF_DLY, 32'h4);
		hw_enable <= 1'h1;
		wait_drv(1'h1);
		`CHK(n >= 6 && n <= 9, 1'h1)
		cyc(2);
		`CHK({hs_oe, hs_gate, ls_gate}, 3'h6)
		hw_enable <= 1'h0;
		cyc(1);
		`CHK({hs_oe, ls_oe, released}, 3'h1)
		wait_drv(1'h0);
		`CHK(n >= 14 && n <= 21, 1'h1)
	endtask
	task automatic t_bus_en;
		wr(`REG_CTRL, 32'h1);
		wait_drv(1'h1);
		`CHK(n >= 5 && n <= 9, 1'h1)
		cyc(2);
		rdr(`REG_STATUS);
		`CHK(rd[3:0], 4'hD)
		wr(`REG_CTRL, 32'h0);
		`CHK({hs_oe, ls_oe, hs_gate}, 3'h0)
		wait_drv(1'h0);
		`CHK(driver_enable_out, 1'h0)
	endtask
	task automatic t_store;
		wr(`REG_CTRL, 32'h4);
		cyc(2);
		aresetn <= 1'h0;
		cyc(3);
		aresetn <= 1'h1;
		wait_rdy();
		rdr(`REG_STATUS);
		`CHK(rd[4], 1'h1)
		rchk(`REG_ENA_DLY, 32'h5);
		rchk(`REG_VOUT, 32'h85);
	endtask
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		cyc(3);
		aresetn <= 1'h1;
		t_load();
		t_restore();
		t_bus();
		t_hw();
		t_bus_en();
		t_store();
		complete_run();
	end
	initial begin
		#100000;
		err_count++;
		complete_run();
	end
endmodule // pin_config_and_gate_output_ctrl_test
